/* File: core/mpio_defines.vh */
// Register offsets, reset values and field positions of the multi-port I/O block.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, four bytes per register index.
`ifndef MPIO_DEFINES_VH
`define MPIO_DEFINES_VH

// ----------------------------------------
// Register indices and byte address width
// ----------------------------------------
`define MPIO_IDX_P3_LATCH 12'h003
`define MPIO_IDX_P4_LATCH 12'h004
`define MPIO_IDX_P5_LATCH 12'h005
`define MPIO_IDX_P6_LATCH 12'h006
`define MPIO_IDX_P4_DRIVE 12'h00a
`define MPIO_IDX_P3_PINS 12'h00d
`define MPIO_IDX_P4_PINS 12'h00e
`define MPIO_IDX_P5_PINS 12'h00f
`define MPIO_IDX_P6_DIR 12'hf9b
`define MPIO_IDX_P6_GATE 12'hf9c
`define MPIO_IDX_P6_KEY 12'hf9d
`define MPIO_IDX_ANA_SEL 12'hf9e
`define MPIO_ADDR_W 14

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MPIO_RST_P3_LATCH 8'hff
`define MPIO_RST_P4_LATCH 8'hff
`define MPIO_RST_P5_LATCH 5'h1f
`define MPIO_RST_P6_LATCH 8'h00
`define MPIO_RST_P4_DRIVE 8'h00
`define MPIO_RST_P6_DIR 8'h00
`define MPIO_RST_P6_GATE 8'hff
`define MPIO_RST_P6_KEY 4'h0
`define MPIO_RST_ANA_SEL 3'h0

// ----------------------------------------
// Field layout
// ----------------------------------------
`define MPIO_P5_W 5
`define MPIO_KEY_LSB 4
`define MPIO_ANA_SEL_W 3
`define MPIO_BITOP_CLR 2'h1
`define MPIO_BITOP_SET 2'h2
`define MPIO_BITOP_TGL 2'h3
`define MPIO_RESP_OKAY 2'h0
`define MPIO_RESP_SLVERR 2'h2

`endif

/* File: core/mpio_sync.v */
// Two-flop synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to aclk.
`timescale 1ns/100ps
`default_nettype none
module mpio_sync #(
	parameter W = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire [W-1:0] din,
	output wire [W-1:0] dout
);
	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;
	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
		end else begin
			meta_r <= din;
			sync_r <= meta_r;
		end
	end
	assign dout = sync_r;
endmodule // mpio_sync
`default_nettype wire

/* File: core/mpio_top.v */
// Four GPIO ports behind an AXI4-Lite slave: two large-current ports, a serial-shared
// port with selectable drive type and a bidirectional port with analog gating.
// Assumes pads resolve the wire from *_o and the active-low *_oen; pin inputs are async.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "mpio_defines.vh"
module mpio_top (
	input wire aclk,
	input wire aresetn,
	input wire [`MPIO_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`MPIO_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [7:0] port3_i,
	output wire [7:0] port3_o,
	output wire [7:0] port3_oen,
	input wire [7:0] port4_i,
	output wire [7:0] port4_o,
	output wire [7:0] port4_oen,
	input wire [4:0] port5_i,
	output wire [4:0] port5_o,
	output wire [4:0] port5_oen,
	input wire [7:0] port6_i,
	output wire [7:0] port6_o,
	output wire [7:0] port6_oen,
	output wire [7:0] port6_analog_en,
	output wire [7:0] analog_in_channel,
	output wire [3:0] key_wakeup_select
);
	// ----------------------------------------
	// Registers and synchronised pins
	// ----------------------------------------
	reg [7:0] port3_output_latch_r;
	reg [7:0] port4_output_latch_r;
	reg [4:0] port5_output_latch_r;
	reg [7:0] port6_data_latch_r;
	reg [7:0] port4_drive_type_r;
	reg [7:0] port6_direction_r;
	reg [7:0] port6_input_gate_r;
	reg [3:0] key_wakeup_select_r;
	reg [2:0] analog_channel_select_r;
	wire [7:0] p3_pins;
	wire [7:0] p4_pins;
	wire [4:0] p5_pins;
	wire [7:0] p6_pins;

	mpio_sync #(.W(8)) u_sync3 (.aclk(aclk), .aresetn(aresetn), .din(port3_i), .dout(p3_pins));
	mpio_sync #(.W(8)) u_sync4 (.aclk(aclk), .aresetn(aresetn), .din(port4_i), .dout(p4_pins));
	mpio_sync #(.W(5)) u_sync5 (.aclk(aclk), .aresetn(aresetn), .din(port5_i), .dout(p5_pins));
	mpio_sync #(.W(8)) u_sync6 (.aclk(aclk), .aresetn(aresetn), .din(port6_i), .dout(p6_pins));

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	// Large-current ports are open-drain: a latch one releases the pin
	assign port3_o = 8'h00;
	assign port3_oen = port3_output_latch_r;
	assign port5_o = 5'h00;
	assign port5_oen = port5_output_latch_r;
	assign port4_o = port4_output_latch_r;
	assign port4_oen = ~(port4_drive_type_r | ~port4_output_latch_r);
	assign port6_o = port6_data_latch_r;
	assign port6_oen = ~port6_direction_r;
	assign port6_analog_en = ~port6_direction_r & ~port6_input_gate_r;
	// Wakeup enables cover port6 pins 7..4, bit 0 for pin 4
	assign key_wakeup_select = key_wakeup_select_r;

	// Selected channel goes to the converter only when that pin is in analog mode
	reg [7:0] ana_route;
	always @* begin
		ana_route = 8'h00;
		ana_route[analog_channel_select_r] = 1'b1;
	end
	assign analog_in_channel = ana_route & port6_analog_en;

	// Digital view of port6: latch, pin, or zero when analog
	wire [7:0] p6_view = (port6_direction_r & port6_data_latch_r) |
		(~port6_direction_r & port6_input_gate_r & p6_pins);

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	reg aw_held_r;
	reg w_held_r;
	reg [`MPIO_ADDR_W-1:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg bvalid_r;
	reg [1:0] bresp_r;

	assign s_axi_awready = ~aw_held_r & ~bvalid_r;
	assign s_axi_wready = ~w_held_r & ~bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire aw_have = aw_held_r | aw_hs;
	wire w_have = w_held_r | w_hs;
	wire [`MPIO_ADDR_W-1:0] wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
	wire [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata;
	wire [3:0] wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
	wire wr_fire = aw_have & w_have & ~bvalid_r;
	wire [11:0] wr_idx = wr_addr[`MPIO_ADDR_W-1:2];
	wire wr_lane0 = wr_fire & wr_strb[0] & (wr_addr[1:0] == 2'h0);

	// Bit operation in byte lane 1: [10:8] bit number, [13:12] op; read-modify-write
	wire [2:0] bit_num = wr_data[10:8];
	wire [1:0] bit_op = wr_data[13:12];
	// A full lane-0 write to the same register wins over a bit operation
	wire wr_bitop = wr_fire & wr_strb[1] & ~wr_strb[0] & (bit_op != 2'h0) & (wr_addr[1:0] == 2'h0);

	function [7:0] bit_apply;
		input [7:0] base;
		input [2:0] num;
		input [1:0] op;
		reg [7:0] m;
		begin
			m = 8'h01 << num;
			case (op)
				`MPIO_BITOP_CLR: bit_apply = base & ~m;
				`MPIO_BITOP_SET: bit_apply = base | m;
				`MPIO_BITOP_TGL: bit_apply = base ^ m;
				default: bit_apply = base;
			endcase
		end
	endfunction

	// Pin registers are read-only: a write to them answers OKAY and is dropped
	reg wr_hit;
	always @* begin
		case (wr_idx)
			`MPIO_IDX_P3_LATCH, `MPIO_IDX_P4_LATCH, `MPIO_IDX_P5_LATCH, `MPIO_IDX_P6_LATCH,
			`MPIO_IDX_P4_DRIVE, `MPIO_IDX_P6_DIR, `MPIO_IDX_P6_GATE, `MPIO_IDX_P6_KEY,
			`MPIO_IDX_ANA_SEL: wr_hit = 1'b1;
			`MPIO_IDX_P3_PINS, `MPIO_IDX_P4_PINS, `MPIO_IDX_P5_PINS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= {`MPIO_ADDR_W{1'b0}};
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `MPIO_RESP_OKAY;
		end else begin
			if (aw_hs) begin
				awaddr_r <= s_axi_awaddr;
			end
			if (w_hs) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? `MPIO_RESP_OKAY : `MPIO_RESP_SLVERR;
			end else begin
				aw_held_r <= aw_have;
				w_held_r <= w_have;
				if (s_axi_bready) begin
					bvalid_r <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// Port registers
	// ----------------------------------------
	// Port5 bit operation runs on the 8-bit read view; only the five real bits are kept
	wire [7:0] p5_bitop = bit_apply({3'h0, p5_pins}, bit_num, bit_op);
	always @(posedge aclk) begin
		if (!aresetn) begin
			port3_output_latch_r <= `MPIO_RST_P3_LATCH;
			port4_output_latch_r <= `MPIO_RST_P4_LATCH;
			port4_drive_type_r <= `MPIO_RST_P4_DRIVE;
			port5_output_latch_r <= `MPIO_RST_P5_LATCH;
			port6_direction_r <= `MPIO_RST_P6_DIR;
			port6_input_gate_r <= `MPIO_RST_P6_GATE;
			port6_data_latch_r <= `MPIO_RST_P6_LATCH;
			key_wakeup_select_r <= `MPIO_RST_P6_KEY;
			analog_channel_select_r <= `MPIO_RST_ANA_SEL;
		end else if (wr_lane0) begin
			case (wr_idx)
				`MPIO_IDX_P3_LATCH: port3_output_latch_r <= wr_data[7:0];
				`MPIO_IDX_P4_LATCH: port4_output_latch_r <= wr_data[7:0];
				`MPIO_IDX_P5_LATCH: port5_output_latch_r <= wr_data[`MPIO_P5_W-1:0];
				`MPIO_IDX_P6_LATCH: port6_data_latch_r <= wr_data[7:0];
				`MPIO_IDX_P4_DRIVE: port4_drive_type_r <= wr_data[7:0];
				`MPIO_IDX_P6_DIR: port6_direction_r <= wr_data[7:0];
				`MPIO_IDX_P6_GATE: port6_input_gate_r <= wr_data[7:0];
				`MPIO_IDX_P6_KEY: key_wakeup_select_r <= wr_data[3:0];
				`MPIO_IDX_ANA_SEL: analog_channel_select_r <= wr_data[`MPIO_ANA_SEL_W-1:0];
				default: ;
			endcase
		end else if (wr_bitop) begin
			// Base is the port's read value, so input bits pick up their pin levels
			case (wr_idx)
				`MPIO_IDX_P3_LATCH: port3_output_latch_r <= bit_apply(p3_pins, bit_num, bit_op);
				`MPIO_IDX_P4_LATCH: port4_output_latch_r <= bit_apply(p4_pins, bit_num, bit_op);
				`MPIO_IDX_P5_LATCH: port5_output_latch_r <= p5_bitop[`MPIO_P5_W-1:0];
				`MPIO_IDX_P6_LATCH: port6_data_latch_r <= bit_apply(p6_view, bit_num, bit_op);
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	reg rvalid_r;
	reg [31:0] rdata_r;
	reg [1:0] rresp_r;
	reg [7:0] rd_val;
	reg rd_hit;
	wire [11:0] rd_idx = s_axi_araddr[`MPIO_ADDR_W-1:2];

	assign s_axi_arready = ~rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// Read data is captured when the address is taken; port5 bits 7:5 read as zero
	always @* begin
		rd_hit = 1'b1;
		case (rd_idx)
			`MPIO_IDX_P3_LATCH: rd_val = port3_output_latch_r;
			`MPIO_IDX_P3_PINS: rd_val = p3_pins;
			`MPIO_IDX_P4_LATCH: rd_val = port4_output_latch_r;
			`MPIO_IDX_P4_PINS: rd_val = p4_pins;
			`MPIO_IDX_P5_LATCH: rd_val = {3'h0, port5_output_latch_r};
			`MPIO_IDX_P5_PINS: rd_val = {3'h0, p5_pins};
			`MPIO_IDX_P6_LATCH: rd_val = p6_view;
			`MPIO_IDX_P4_DRIVE: rd_val = port4_drive_type_r;
			`MPIO_IDX_P6_DIR: rd_val = port6_direction_r;
			`MPIO_IDX_P6_GATE: rd_val = port6_input_gate_r;
			`MPIO_IDX_P6_KEY: rd_val = {4'h0, key_wakeup_select_r};
			`MPIO_IDX_ANA_SEL: rd_val = {5'h00, analog_channel_select_r};
			default: begin
				rd_val = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= `MPIO_RESP_OKAY;
		end else if (s_axi_arvalid & ~rvalid_r) begin
			rvalid_r <= 1'b1;
			rdata_r <= {24'h0, rd_val};
			rresp_r <= rd_hit ? `MPIO_RESP_OKAY : `MPIO_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end
endmodule // mpio_top
`default_nettype wire

/* File: sim/mpio_pins.sv */
// Outside circuitry on the four ports: a released line takes the outside level.
// Assumes *_oen is active low; ext* is the pull-up or outside driver level.
`timescale 1ns/100ps
`default_nettype none
module mpio_pins (
	input wire logic [7:0] port3_o,
	input wire logic [7:0] port3_oen,
	input wire logic [7:0] ext3,
	output wire logic [7:0] port3_i,
	input wire logic [7:0] port4_o,
	input wire logic [7:0] port4_oen,
	input wire logic [7:0] ext4,
	output wire logic [7:0] port4_i,
	input wire logic [4:0] port5_o,
	input wire logic [4:0] port5_oen,
	input wire logic [4:0] ext5,
	output wire logic [4:0] port5_i,
	input wire logic [7:0] port6_o,
	input wire logic [7:0] port6_oen,
	input wire logic [7:0] ext6,
	output wire logic [7:0] port6_i
);
	assign port3_i = (port3_o & ~port3_oen) | (ext3 & port3_oen);
	assign port4_i = (port4_o & ~port4_oen) | (ext4 & port4_oen);
	assign port5_i = (port5_o & ~port5_oen) | (ext5 & port5_oen);
	assign port6_i = (port6_o & ~port6_oen) | (ext6 & port6_oen);
endmodule // mpio_pins
`default_nettype wire

/* File: sim/mpio_top_props.sv */
// Bus and pin relations of the multi-port I/O block.
// Assumes one clock aclk and synchronous active-low aresetn.
`timescale 1ns/100ps
`default_nettype none
module mpio_top_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] port3_oen,
	input wire logic [7:0] port4_o,
	input wire logic [7:0] port4_oen,
	input wire logic [4:0] port5_oen,
	input wire logic [7:0] port6_oen,
	input wire logic [7:0] port6_analog_en,
	input wire logic [7:0] analog_in_channel
);
	// ----
	// Handshakes and pin relations
	// ----
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	wr_answer_a: assert property (wr_take |=> s_axi_bvalid ##1 (s_axi_bvalid || $past(s_axi_bready)))
		else $error("write not answered");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer stuck");
	rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
		else $error("read not answered");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data unstable");
	rst_vals_a: assert property ($rose(aresetn) |-> port3_oen == 8'hff && port4_oen == 8'hff
		&& port5_oen == 5'h1f && port6_oen == 8'hff && port6_analog_en == 8'h00)
		else $error("pin state after reset wrong");
	p4_sink_a: assert property ((~port4_o & port4_oen) == 8'h00)
		else $error("low latch bit not driven");
	p6_analog_a: assert property ((port6_analog_en & ~port6_oen) == 8'h00)
		else $error("analog enabled on output pin");
	ana_route_a: assert property ($onehot0(analog_in_channel) && (analog_in_channel & ~port6_analog_en) == 8'h00)
		else $error("analog routing wrong");
endmodule // mpio_top_props
bind mpio_top mpio_top_props mpio_top_props_inst (.*);
`default_nettype wire

/* File: sim/tb_multi_port_io_block.sv */
// Self-checking bench for the multi-port I/O block over AXI4-Lite.
// Assumes mpio_pins models the outside circuitry on every pin.
`timescale 1ns/100ps
`default_nettype none
module tb_multi_port_io_block;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [7:0] port3_i, port3_o, port3_oen, port4_i, port4_o, port4_oen, port6_i, port6_o, port6_oen;
	wire [7:0] port6_analog_en, analog_in_channel;
	wire [4:0] port5_i, port5_o, port5_oen;
	wire [3:0] key_wakeup_select;
	logic [7:0] ext3 = 8'hff, ext4 = 8'hff, ext6 = 8'h00;
	logic [4:0] ext5 = 5'h1f;
	logic [31:0] rv;
	logic [1:0] rs;
	int num_errors = 0;
	int tests_run = 0;
	mpio_top mpio_top_inst (.*);
	mpio_pins mpio_pins_inst (.*);
	initial forever #12.5 aclk = ~aclk;
	// ----
	// Bus tasks
	// ----
	task automatic complete_run;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
		int n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'b0;
		rs = s_axi_bresp;
		if (n >= 50) begin
			num_errors++;
			complete_run();
		end
	endtask
	task automatic rd(input logic [13:0] a);
		int n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		s_axi_rready <= 1'b0;
		rv = s_axi_rdata;
		rs = s_axi_rresp;
		if (n >= 50) begin
			num_errors++;
			complete_run();
		end
	endtask
	task automatic rc(input logic [13:0] a, input logic [31:0] e);
		rd(a);
		chk(rv, e);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset;
		chk({port3_oen, port4_oen, port6_oen, 3'h0, port5_oen}, 32'hffffff1f);
		chk({port3_o, 3'h0, port5_o}, 32'h00);
		rc(14'h000c, 32'hff);
		rc(14'h0010, 32'hff);
		rc(14'h0028, 32'h00);
		rc(14'h0018, 32'h00);
		rc(14'h3e6c, 32'h00);
		rc(14'h3e70, 32'hff);
	endtask
	task automatic t_p3;
		ext3 <= 8'h3c;
		repeat (3) @(posedge aclk);
		rc(14'h0034, 32'h3c);
		wr(14'h000c, 32'h5a, 4'h1);
		chk(32'(port3_oen), 32'h5a);
		rc(14'h000c, 32'h5a);
		rc(14'h0034, 32'h18);
	endtask
	task automatic t_p4;
		ext4 <= 8'h55;
		wr(14'h0010, 32'h0f, 4'h1);
		wr(14'h0028, 32'hf3, 4'h1);
		chk({port4_o, port4_oen}, 32'h0f0c);
		rc(14'h0038, 32'h07);
		rc(14'h0010, 32'h0f);
		wr(14'h0010, 32'hff, 4'h1);
		wr(14'h0028, 32'h00, 4'h1);
		rc(14'h0038, 32'h55);
	endtask
	task automatic t_p5;
		ext5 <= 5'h17;
		wr(14'h0014, 32'he0, 4'h1);
		rd(14'h0014);
		chk(rv & 32'h1f, 32'h00);
		wr(14'h0014, 32'h0a, 4'h1);
		chk(32'(port5_oen), 32'h0a);
		rd(14'h003c);
		chk(rv & 32'h1f, 32'h02);
	endtask
	task automatic t_p6;
		ext6 <= 8'ha5;
		wr(14'h3e6c, 32'h0f, 4'h1);
		wr(14'h0018, 32'h5a, 4'h1);
		wr(14'h3e70, 32'h3c, 4'h1);
		chk({port6_o, port6_oen, port6_analog_en}, 32'h5af0c0);
		rc(14'h0018, 32'h2a);
		wr(14'h3e78, 32'h7, 4'h1);
		chk(32'(analog_in_channel), 32'h80);
		wr(14'h3e78, 32'h0, 4'h1);
		chk(32'(analog_in_channel), 32'h00);
		wr(14'h3e74, 32'ha, 4'h1);
		chk(32'(key_wakeup_select), 32'ha);
		wr(14'h0018, 32'h1300, 4'h2);
		chk(32'(port6_o), 32'h22);
		wr(14'h0018, 32'h2700, 4'h2);
		chk(32'(port6_o), 32'ha2);
		wr(14'h0018, 32'h3100, 4'h2);
		chk(32'(port6_o), 32'h20);
	endtask
	task automatic t_err;
		wr(14'h0100, 32'h12, 4'h1);
		chk(32'(rs), 32'(`MPIO_RESP_SLVERR));
		rd(14'h0100);
		chk(32'(rs), 32'(`MPIO_RESP_SLVERR));
		wr(14'h0034, 32'h00, 4'h1);
		chk(32'(rs), 32'(`MPIO_RESP_OKAY));
		rc(14'h000c, 32'h5a);
	endtask
	task automatic t_rerun;
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({port3_oen, port4_oen, port6_oen, 3'h0, port5_oen}, 32'hffffff1f);
		rc(14'h000c, 32'hff);
		rc(14'h0018, 32'ha5);
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_p3();
		t_p4();
		t_p5();
		t_p6();
		t_err();
		t_rerun();
		complete_run();
	end
endmodule // tb_multi_port_io_block
`default_nettype wire
